//--- pkg/krr_map.svh
// constants of the lane reconfiguration request link
`ifndef KRR_MAP_SVH
`define KRR_MAP_SVH
`define KRR_LANES         4
`define KRR_MAIN_W        6
`define KRR_POST_W        5
`define KRR_PRE_W         4
`define KRR_TAP_SEL_W     3
`define KRR_TAP_MAIN      3'h4
`define KRR_TAP_POST      3'h2
`define KRR_TAP_PRE       3'h1
`define KRR_DFE_W         2
`define KRR_DFE_OFF       2'h0
`define KRR_DFE_SHOT      2'h1
`define KRR_CTLE_W        4
`define KRR_CTLE_OFF      4'h0
`define KRR_CTLE_MAX      4'hf
`define KRR_CTLE_MODE_W   2
`define KRR_CTLE_MODE_VAL 2'h0
`define KRR_PCS_W         6
`define KRR_PCS_AN        6'h01
`define KRR_PCS_LT        6'h02
`define KRR_PCS_DATA      6'h20
`define KRR_TRAINED_BIT0  0
`define KRR_TRAINED_STEP  8
`endif

//--- pkg/krr_pkg.sv
// types of the lane reconfiguration request link
package krr_pkg;
    typedef enum logic [1:0] {
        KRR_REQ_TX_EQ,
        KRR_REQ_PCS,
        KRR_REQ_DFE,
        KRR_REQ_CTLE
    } krr_req_t;
    typedef enum logic [1:0] {
        KRR_TAP_SEL_MAIN,
        KRR_TAP_SEL_POST,
        KRR_TAP_SEL_PRE
    } krr_tap_t;
    typedef enum logic [1:0] {
        KRR_MODE_AN,
        KRR_MODE_LT,
        KRR_MODE_DATA
    } krr_pcs_t;
endpackage : krr_pkg

//--- pkg/krr_if.sv
// link between the phy request side and the reconfiguration bundle
`timescale 1ns/100ps
`include "krr_map.svh"
interface krr_if;
    logic [3:0]  lane_reconfig_in_progress;
    logic [3:0]  tx_eq_reconfig_go;
    logic [23:0] main_tap_value;
    logic [19:0] post_cursor_tap_value;
    logic [15:0] pre_cursor_tap_value;
    logic [11:0] tap_select_onehot;
    logic [3:0]  pcs_reconfig_go;
    logic [3:0]  feedback_eq_go;
    logic [7:0]  feedback_eq_mode;
    logic [3:0]  linear_eq_go;
    logic [15:0] linear_eq_value;
    logic [7:0]  linear_eq_mode;
    logic [5:0]  pcs_mode_code;
    logic [3:0]  custom_rx_eq_enable;
    logic [3:0]  custom_rx_eq_done;
    logic        config_image_loaded;
    modport phy (
        input  lane_reconfig_in_progress, custom_rx_eq_done,
               config_image_loaded,
        output tx_eq_reconfig_go, main_tap_value, post_cursor_tap_value,
               pre_cursor_tap_value, tap_select_onehot, pcs_reconfig_go,
               feedback_eq_go, feedback_eq_mode, linear_eq_go,
               linear_eq_value, linear_eq_mode, pcs_mode_code,
               custom_rx_eq_enable
    );
    modport bundle (
        output lane_reconfig_in_progress, custom_rx_eq_done,
               config_image_loaded,
        input  tx_eq_reconfig_go, main_tap_value, post_cursor_tap_value,
               pre_cursor_tap_value, tap_select_onehot, pcs_reconfig_go,
               feedback_eq_go, feedback_eq_mode, linear_eq_go,
               linear_eq_value, linear_eq_mode, pcs_mode_code,
               custom_rx_eq_enable
    );
endinterface : krr_if

//--- design/krr_phy_req.sv
// phy end: per-lane reconfiguration request issuer
`timescale 1ns/100ps
`include "krr_map.svh"
module krr_phy_req
    import krr_pkg::*;
#(
    parameter int LANES = `KRR_LANES
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clk_en,
    // user request side
    input  wire logic [LANES-1:0]     i_req_valid,
    input  wire krr_req_t             i_req_kind,
    input  wire logic [5:0]           i_main_tap,
    input  wire logic [4:0]           i_post_tap,
    input  wire logic [3:0]           i_pre_tap,
    input  wire krr_tap_t             i_tap_sel,
    input  wire logic                 i_dfe_on,
    input  wire logic [3:0]           i_ctle_val,
    input  wire krr_pcs_t             i_pcs_mode,
    input  wire logic [31:0]          i_trained_status,
    input  wire logic [LANES-1:0]     i_rx_trained,
    output logic      [LANES-1:0]     o_req_ready,
    output logic      [LANES-1:0]     o_rx_eq_complete,
    // link to bundle
    krr_if.phy                        link
);
    if (LANES != 4) begin : g_lane_chk
        $error("krr_phy_req serves four lanes only");
    end

    // ==========================================================
    // per-lane state, plus the shared pcs code and reset
    logic [LANES-1:0] go_reg;
    logic [LANES-1:0] busy_seen_reg;
    logic [LANES-1:0] pend_reg;
    krr_req_t         kind_reg [LANES];
    logic [5:0]       main_reg [LANES];
    logic [4:0]       post_reg [LANES];
    logic [3:0]       pre_reg  [LANES];
    logic [2:0]       sel_reg  [LANES];
    logic [1:0]       dfe_reg  [LANES];
    logic [3:0]       ctle_reg [LANES];
    logic [5:0]       pcs_reg;
    logic             rst_all;

    assign rst_all = i_rst | link.config_image_loaded;

    // ==========================================================
    // handshake: ready when lane idle and not busy
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            o_req_ready[l] = ~pend_reg[l] & ~go_reg[l]
                & ~link.lane_reconfig_in_progress[l];
        end
    end

    // ==========================================================
    // request capture and start strobe (one cycle)
    always_ff @(posedge i_sys_clk) begin
        if (rst_all) begin
            go_reg        <= '0;
            pend_reg      <= '0;
            busy_seen_reg <= '0;
        end else if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                go_reg[l] <= 1'b0;
                if (i_req_valid[l] && o_req_ready[l]) begin
                    go_reg[l]        <= 1'b1;
                    pend_reg[l]      <= 1'b1;
                    busy_seen_reg[l] <= 1'b0;
                end else if (pend_reg[l]) begin
                    if (link.lane_reconfig_in_progress[l]) begin
                        busy_seen_reg[l] <= 1'b1;
                    end else if (busy_seen_reg[l]) begin
                        pend_reg[l] <= 1'b0;
                    end
                end
            end
        end
    end

    // ==========================================================
    // settings, frozen while a lane request is pending
    always_ff @(posedge i_sys_clk) begin
        if (rst_all) begin
            for (int l = 0; l < LANES; l++) begin
                kind_reg[l] <= KRR_REQ_TX_EQ;
                main_reg[l] <= 6'h00;
                post_reg[l] <= 5'h00;
                pre_reg[l]  <= 4'h0;
                sel_reg[l]  <= `KRR_TAP_MAIN;
                dfe_reg[l]  <= `KRR_DFE_OFF;
                ctle_reg[l] <= `KRR_CTLE_OFF;
            end
        end else if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (i_req_valid[l] && o_req_ready[l]) begin
                    kind_reg[l] <= i_req_kind;
                    main_reg[l] <= i_main_tap;
                    post_reg[l] <= i_post_tap;
                    pre_reg[l]  <= i_pre_tap;
                    unique case (i_tap_sel)
                        KRR_TAP_SEL_POST: sel_reg[l] <= `KRR_TAP_POST;
                        KRR_TAP_SEL_PRE:  sel_reg[l] <= `KRR_TAP_PRE;
                        default:          sel_reg[l] <= `KRR_TAP_MAIN;
                    endcase
                    dfe_reg[l]  <= i_dfe_on ? `KRR_DFE_SHOT
                                            : `KRR_DFE_OFF;
                    ctle_reg[l] <= i_ctle_val;
                end
            end
        end
    end

    // ==========================================================
    // pcs mode code, shared by all lanes
    always_ff @(posedge i_sys_clk) begin
        if (rst_all) begin
            pcs_reg <= `KRR_PCS_AN;
        end else if (i_clk_en && (|(i_req_valid & o_req_ready))
                     && i_req_kind == KRR_REQ_PCS) begin
            unique case (i_pcs_mode)
                KRR_MODE_LT:   pcs_reg <= `KRR_PCS_LT;
                KRR_MODE_DATA: pcs_reg <= `KRR_PCS_DATA;
                default:       pcs_reg <= `KRR_PCS_AN;
            endcase
        end
    end

    // ==========================================================
    // outputs, packed lane 0 lowest
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            link.tx_eq_reconfig_go[l] = go_reg[l]
                & (kind_reg[l] == KRR_REQ_TX_EQ);
            link.pcs_reconfig_go[l]   = go_reg[l]
                & (kind_reg[l] == KRR_REQ_PCS);
            link.feedback_eq_go[l]    = go_reg[l]
                & (kind_reg[l] == KRR_REQ_DFE);
            link.linear_eq_go[l]      = go_reg[l]
                & (kind_reg[l] == KRR_REQ_CTLE);
            link.main_tap_value[l*6 +: 6]        = main_reg[l];
            link.post_cursor_tap_value[l*5 +: 5] = post_reg[l];
            link.pre_cursor_tap_value[l*4 +: 4]  = pre_reg[l];
            link.tap_select_onehot[l*3 +: 3]     = sel_reg[l];
            link.feedback_eq_mode[l*2 +: 2]      = dfe_reg[l];
            link.linear_eq_value[l*4 +: 4]       = ctle_reg[l];
            link.linear_eq_mode[l*2 +: 2] = `KRR_CTLE_MODE_VAL;
            link.custom_rx_eq_enable[l] = i_trained_status[
                `KRR_TRAINED_BIT0 + l*`KRR_TRAINED_STEP];
            o_rx_eq_complete[l] = link.custom_rx_eq_done[l]
                & i_rx_trained[l];
        end
        link.pcs_mode_code = pcs_reg;
    end
endmodule : krr_phy_req

//--- design/krr_bundle_end.sv
// bundle end: accepts start strobes and reports busy
`timescale 1ns/100ps
`include "krr_map.svh"
module krr_bundle_end
    import krr_pkg::*;
#(
    parameter int LANES     = `KRR_LANES,
    parameter int BUSY_CYCS = 8
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clk_en,
    // user side
    input  wire logic                 i_image_loaded,
    input  wire logic [LANES-1:0]     i_eq_done,
    output logic      [LANES-1:0]     o_start_seen,
    output logic      [23:0]          o_main_tap,
    output logic      [5:0]           o_pcs_mode,
    // link to phy
    krr_if.bundle                     link
);
    if (LANES != 4 || BUSY_CYCS < 1 || BUSY_CYCS > 255) begin : g_par_chk
        $error("krr_bundle_end parameters out of range");
    end

    // ==========================================================
    // busy counters per lane
    logic [7:0]       cnt_reg [LANES];
    logic [LANES-1:0] busy_reg;
    logic [LANES-1:0] start_w;
    logic [23:0]      main_reg;
    logic [5:0]       pcs_reg;

    assign start_w = link.tx_eq_reconfig_go | link.pcs_reconfig_go
                   | link.feedback_eq_go | link.linear_eq_go;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            busy_reg <= '0;
            for (int l = 0; l < LANES; l++) cnt_reg[l] <= 8'h00;
        end else if (i_clk_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (start_w[l] && !busy_reg[l]) begin
                    busy_reg[l] <= 1'b1;
                    cnt_reg[l]  <= 8'(BUSY_CYCS - 1);
                end else if (busy_reg[l]) begin
                    if (cnt_reg[l] == 8'h00) busy_reg[l] <= 1'b0;
                    else cnt_reg[l] <= cnt_reg[l] - 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // captured values
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            main_reg     <= 24'h000000;
            pcs_reg      <= 6'h00;
            o_start_seen <= '0;
        end else if (i_clk_en) begin
            o_start_seen <= start_w;
            if (|link.tx_eq_reconfig_go) main_reg <= link.main_tap_value;
            if (|link.pcs_reconfig_go)   pcs_reg  <= link.pcs_mode_code;
        end
    end

    assign o_main_tap                = main_reg;
    assign o_pcs_mode                = pcs_reg;
    assign link.lane_reconfig_in_progress = busy_reg;
    assign link.custom_rx_eq_done    = i_eq_done;
    assign link.config_image_loaded  = i_image_loaded;
endmodule : krr_bundle_end

//--- tb/krr_link_chk.sv
// assertions on the link between the two request ends
`timescale 1ns/100ps
module krr_link_chk (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        config_image_loaded,
    // link signals
    input  wire logic [3:0]  lane_reconfig_in_progress,
    input  wire logic [3:0]  tx_eq_reconfig_go,
    input  wire logic [3:0]  pcs_reconfig_go,
    input  wire logic [3:0]  feedback_eq_go,
    input  wire logic [3:0]  linear_eq_go,
    input  wire logic [7:0]  feedback_eq_mode,
    input  wire logic [15:0] linear_eq_value,
    input  wire logic [7:0]  linear_eq_mode,
    input  wire logic [11:0] tap_select_onehot,
    input  wire logic [5:0]  pcs_mode_code
);
    // ==========================================
    // helpers
    logic [3:0] any_go;
    assign any_go = tx_eq_reconfig_go | pcs_reconfig_go | feedback_eq_go
                  | linear_eq_go;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst || config_image_loaded);
    // bundle built with two busy cycles
    sequence busy_two;
        lane_reconfig_in_progress[0] [*2] ##1 !lane_reconfig_in_progress[0];
    endsequence
    // ==========================================
    // properties
    dfe_mode_legal_a: assert property (
        (feedback_eq_mode & 8'haa) == 8'h00)
        else $error("dfe mode reserved code");
    ctle_mode_zero_a: assert property (linear_eq_mode == 8'h00)
        else $error("ctle mode not zero");
    pcs_code_legal_a: assert property (
        pcs_mode_code inside {6'h01, 6'h02, 6'h20})
        else $error("pcs mode code invalid");
    tap_sel_legal_a: assert property (
        $onehot(tap_select_onehot[2:0]) && $onehot(tap_select_onehot[5:3])
        && $onehot(tap_select_onehot[8:6]) && $onehot(tap_select_onehot[11:9]))
        else $error("tap select not one-hot");
    no_start_busy_a: assert property (
        (any_go & lane_reconfig_in_progress) == 4'h0)
        else $error("start while lane busy");
    go_pulse_a: assert property (
        |any_go |=> (any_go & $past(any_go)) == 4'h0)
        else $error("start longer than one cycle");
    busy_follows_a: assert property (any_go[0] |=> busy_two)
        else $error("busy not shown after start");
    dfe_hold_a: assert property (
        feedback_eq_go[0] |=> $stable(feedback_eq_mode[1:0]) [*3])
        else $error("dfe mode moved while busy");
    ctle_hold_a: assert property (
        linear_eq_go[1] |=> $stable(linear_eq_value[7:4]) [*3])
        else $error("ctle value moved while busy");
endmodule : krr_link_chk

//--- tb/kr4_lane_reconfig_request_bench.sv
// self-checking bench for both ends of the request link
`timescale 1ns/100ps
module kr4_lane_reconfig_request_bench;
    import krr_pkg::*;
    logic        i_sys_clk;
    logic        i_rst;
    logic        i_clk_en;
    logic        i_image_loaded;
    logic [3:0]  i_req_valid;
    krr_req_t    i_req_kind;
    logic [5:0]  i_main_tap;
    logic [4:0]  i_post_tap;
    logic [3:0]  i_pre_tap;
    krr_tap_t    i_tap_sel;
    logic        i_dfe_on;
    logic [3:0]  i_ctle_val;
    krr_pcs_t    i_pcs_mode;
    logic [31:0] i_trained_status;
    logic [3:0]  i_rx_trained;
    logic [3:0]  i_eq_done;
    logic [3:0]  o_req_ready;
    logic [3:0]  o_rx_eq_complete;
    logic [3:0]  o_start_seen;
    logic [23:0] o_main_tap;
    logic [5:0]  o_pcs_mode;
    logic [5:0]  exp_pcs;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;
    // ==========================================
    // ends, link and checker
    krr_if lk ();
    krr_phy_req i_krr_phy_req (.i_sys_clk, .i_rst, .i_clk_en,
        .i_req_valid, .i_req_kind, .i_main_tap, .i_post_tap, .i_pre_tap,
        .i_tap_sel, .i_dfe_on, .i_ctle_val, .i_pcs_mode, .i_trained_status,
        .i_rx_trained, .o_req_ready, .o_rx_eq_complete, .link(lk));
    krr_bundle_end #(.BUSY_CYCS(2)) i_krr_bundle_end (.i_sys_clk, .i_rst,
        .i_clk_en, .i_image_loaded, .i_eq_done, .o_start_seen,
        .o_main_tap, .o_pcs_mode, .link(lk));
    krr_link_chk i_krr_link_chk (.i_sys_clk, .i_rst,
        .config_image_loaded(lk.config_image_loaded),
        .lane_reconfig_in_progress(lk.lane_reconfig_in_progress),
        .tx_eq_reconfig_go(lk.tx_eq_reconfig_go),
        .pcs_reconfig_go(lk.pcs_reconfig_go),
        .feedback_eq_go(lk.feedback_eq_go), .linear_eq_go(lk.linear_eq_go),
        .feedback_eq_mode(lk.feedback_eq_mode),
        .linear_eq_value(lk.linear_eq_value),
        .linear_eq_mode(lk.linear_eq_mode),
        .tap_select_onehot(lk.tap_select_onehot),
        .pcs_mode_code(lk.pcs_mode_code));
    // ==========================================
    // clock, timeout and tasks
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task wrap_up;
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task check(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task send(input logic [3:0] m, input krr_req_t k);
        @(posedge i_sys_clk);
        i_req_valid <= m;
        i_req_kind  <= k;
        @(posedge i_sys_clk);
        i_req_valid <= 4'h0;
        #1;
    endtask : send
    task settle(input logic [3:0] m);
        for (int i = 0; i < 20 && (o_req_ready & m) !== m; i++) begin
            @(posedge i_sys_clk);
            #1;
        end
        check(o_req_ready & m, m);
    endtask : settle
    // ==========================================
    // scenarios
    initial begin
        {i_rst, i_clk_en, i_image_loaded, i_req_valid, i_dfe_on} = 8'hc0;
        {i_main_tap, i_post_tap, i_pre_tap, i_ctle_val} = 19'h0;
        {i_trained_status, i_rx_trained, i_eq_done} = 40'h0;
        i_req_kind = KRR_REQ_TX_EQ;
        i_tap_sel = KRR_TAP_SEL_MAIN;
        i_pcs_mode = KRR_MODE_AN;
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge i_sys_clk);
            {i_main_tap, i_post_tap, i_pre_tap} <= {6'h2a + 6'(i), 9'h139};
            i_tap_sel <= krr_tap_t'(i);
            send(4'h1 << i, KRR_REQ_TX_EQ);
            check(lk.tx_eq_reconfig_go, 4'h1 << i);
            check(lk.main_tap_value[6*i +: 6], 6'h2a + 6'(i));
            check(lk.post_cursor_tap_value[5*i +: 5], 5'h13);
            check(lk.pre_cursor_tap_value[4*i +: 4], 4'h9);
            check(lk.tap_select_onehot[3*i +: 3], 3'h4 >> i);
            check(o_req_ready[i], 1'b0);
            settle(4'h1 << i);
            check(o_main_tap[6*i +: 6], 6'h2a + 6'(i));
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge i_sys_clk);
            i_pcs_mode <= krr_pcs_t'(i);
            exp_pcs = (i == 0) ? 6'h01 : (i == 1) ? 6'h02 : 6'h20;
            send(4'h8, KRR_REQ_PCS);
            check(lk.pcs_reconfig_go, 4'h8);
            check(lk.pcs_mode_code, exp_pcs);
            settle(4'h8);
            check(o_pcs_mode, exp_pcs);
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge i_sys_clk);
            i_dfe_on <= i[0];
            i_ctle_val <= 4'hf * 4'(i);
            send(4'h1, KRR_REQ_DFE);
            check(lk.feedback_eq_go, 4'h1);
            check(lk.feedback_eq_mode[1:0], 2'(i));
            settle(4'h1);
            send(4'h2, KRR_REQ_CTLE);
            check(lk.linear_eq_go, 4'h2);
            check(lk.linear_eq_value[7:4], 4'hf * 4'(i));
            check(lk.linear_eq_mode, 8'h00);
            settle(4'h2);
        end
        n = 0;
        @(posedge i_sys_clk);
        i_req_valid <= 4'h1;
        i_req_kind <= KRR_REQ_TX_EQ;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_sys_clk);
            if (i == 3) i_req_valid <= 4'h0;
            #1;
            n += lk.tx_eq_reconfig_go[0];
            if (i == 1) check(o_start_seen, 4'h1);
        end
        check(n, 1);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        i_req_valid <= 4'h4;
        @(posedge i_sys_clk);
        #1;
        check(lk.tx_eq_reconfig_go, 4'h0);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        i_req_valid <= 4'h0;
        #1;
        check(o_req_ready, 4'hf);
        @(posedge i_sys_clk);
        i_trained_status <= 32'h0100_0001;
        i_rx_trained <= 4'h6;
        i_eq_done <= 4'hc;
        @(posedge i_sys_clk);
        #1;
        check(lk.custom_rx_eq_enable, 4'h9);
        check(o_rx_eq_complete, 4'h4);
        check(lk.custom_rx_eq_done, 4'hc);
        @(posedge i_sys_clk);
        i_image_loaded <= 1'b1;
        @(posedge i_sys_clk);
        i_image_loaded <= 1'b0;
        #1;
        check(lk.pcs_mode_code, 6'h01);
        check(lk.tap_select_onehot, 12'h924);
        check(lk.main_tap_value, 24'h0);
        wrap_up();
    end
endmodule : kr4_lane_reconfig_request_bench
